// File: srg_pkg.sv
`default_nettype none
package srg_pkg;

   // ---------------------------------------------------------------
   // Register map: byte address is four times the index
   // ---------------------------------------------------------------
   localparam int SRG_ADDR_W = 8;
   localparam int SRG_IDX_W = 4;
   localparam int SRG_NUM_RW = 12;
   localparam logic [3:0] SRG_R_CTRL = 4'h0;
   localparam logic [3:0] SRG_R_SPD_HI = 4'h1;
   localparam logic [3:0] SRG_R_SPD_LO = 4'h2;
   localparam logic [3:0] SRG_R_OBS_HI = 4'h3;
   localparam logic [3:0] SRG_R_OBS_LO = 4'h4;
   localparam logic [3:0] SRG_R_FILT = 4'h5;
   localparam logic [3:0] SRG_R_COMP = 4'h6;
   localparam logic [3:0] SRG_R_SWITCH = 4'h7;
   localparam logic [3:0] SRG_R_INV = 4'h8;
   localparam logic [3:0] SRG_R_LIMIT = 4'h9;
   localparam logic [3:0] SRG_R_ILIM = 4'ha;
   localparam logic [3:0] SRG_R_OUTF = 4'hb;
   localparam logic [3:0] SRG_R_STATUS = 4'hc;
   localparam logic [3:0] SRG_R_FREQ = 4'hd;
   localparam logic [3:0] SRG_R_SPEED = 4'he;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int SRG_CTRL_MODE_LSB = 0;
   localparam int SRG_CTRL_ACCDEC = 2;
   localparam int SRG_CTRL_LOOP_EN = 3;
   localparam int SRG_CTRL_INTEG_EN = 4;
   localparam int SRG_CTRL_LPF_EN = 5;
   localparam int SRG_CTRL_COMP_EN = 6;
   localparam int SRG_CTRL_MON1_SEL = 7;
   localparam int SRG_CTRL_MON2_SEL = 8;

   typedef enum logic [1:0] {
      SRG_MODE_SCALAR_ENC,
      SRG_MODE_SENSORLESS,
      SRG_MODE_SENSORED,
      SRG_MODE_MAGNET
   } srg_mode_t;

   // ---------------------------------------------------------------
   // Reset values, index order
   // ---------------------------------------------------------------
   localparam logic [31:0] SRG_RST_VALS [SRG_NUM_RW] = '{
      32'h0000_0198, 32'h0040_0100, 32'h0040_0100, 32'h0040_0080,
      32'h0040_0080, 32'h4000_4000, 32'h0100_0100, 32'h0064_0032,
      32'h006d_0147, 32'h0032_0032, 32'h0258_03e8, 32'h0000_8000};

   // ---------------------------------------------------------------
   // Scaling and limits
   // ---------------------------------------------------------------
   localparam int SRG_GAIN_SH = 8;
   localparam int SRG_COEF_SH = 16;
   localparam int SRG_Q_SH = 8;
   localparam logic [15:0] SRG_FRAC_MAX = 16'hffff;
   localparam int SRG_PCT_DIV = 1000;
   localparam logic [15:0] SRG_LIM_MIN = 16'h0001;
   localparam logic [15:0] SRG_LIM_MAX = 16'h0064;
   localparam logic [15:0] SRG_ILIM_MAX = 16'h0bb8;
   localparam int SRG_S16_MIN = -32768;
   localparam int SRG_S16_MAX = 32767;

   // ---------------------------------------------------------------
   // Control sample period
   // ---------------------------------------------------------------
   localparam int SRG_CLK_PERIOD_NS = 25;
   localparam int SRG_SAMPLE_TIME_NS = 250000;
   localparam int SRG_SAMPLE_CYC = SRG_SAMPLE_TIME_NS / SRG_CLK_PERIOD_NS;

   localparam logic [1:0] SRG_RESP_OKAY = 2'h0;
   localparam logic [1:0] SRG_RESP_SLVERR = 2'h2;
   localparam logic [1:0] SRG_RESP_DECERR = 2'h3;

endpackage
`default_nettype wire

// File: srg_lerp.sv
`timescale 1ns/1ps
`default_nettype none
// Linear blend between a low-speed and a high-speed setting
module srg_lerp
   import srg_pkg::*;
#(
   parameter int W = 16
)
(
   input wire logic [W-1:0] lo_val,
   input wire logic [W-1:0] hi_val,
   input wire logic [15:0] frac,
   output logic [W-1:0] blend
);

   logic signed [W:0] diff;
   logic signed [W+17:0] prod;
   logic signed [W+17:0] sum;

   assign diff = $signed({1'b0, hi_val}) - $signed({1'b0, lo_val});
   assign prod = diff * $signed({1'b0, frac});
   assign sum = $signed({18'h0_0000, lo_val}) + (prod >>> SRG_COEF_SH);
   // Full-scale frac must land on the high setting exactly; the product alone stops one count short when the high setting is above the low
   assign blend = (frac == SRG_FRAC_MAX) ? hi_val : sum[W-1:0];

endmodule // srg_lerp
`default_nettype wire

// File: srg_speed_regulator.sv
`timescale 1ns/1ps
`default_nettype none
module srg_speed_regulator
   import srg_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SRG_SAMPLE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SRG_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [SRG_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic signed [15:0] freq_ref,
   input wire logic signed [15:0] encoder_speed,
   input wire logic signed [15:0] raw_speed_est,
   input wire logic run,
   input wire logic ramping,
   input wire logic loop_off_in,
   input wire logic integ_reset_in,
   output logic signed [15:0] freq_cmd,
   output logic signed [15:0] delta_f,
   output logic signed [15:0] analog_monitor_out_1,
   output logic signed [15:0] analog_monitor_out_2
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [SRG_NUM_RW-1:0][31:0] regs;
      logic [31:0] tick_cnt;
      logic signed [31:0] integ;
      logic signed [31:0] oint;
      logic signed [31:0] filt;
      logic signed [31:0] dfo;
      logic signed [15:0] est;
      logic signed [15:0] speed_fb;
      logic signed [15:0] freq_cmd;
      logic signed [15:0] delta_f;
      logic signed [15:0] mon1;
      logic signed [15:0] mon2;
      logic at_hi;
      logic at_lo;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } srg_state_t;

   srg_state_t st_ff;
   srg_state_t nxt_st;

   localparam int NBLEND = 6;
   logic [NBLEND-1:0][15:0] blend_lo;
   logic [NBLEND-1:0][15:0] blend_hi;
   logic [NBLEND-1:0][15:0] blend_out;
   logic [15:0] frac;
   logic [15:0] sch_x;
   logic [15:0] sch_lo;
   logic [15:0] sch_hi;
   logic [15:0] sch_inv;
   logic [31:0] sch_prod;
   logic aw_go;
   srg_mode_t mode;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic signed [31:0] sat(input logic signed [31:0] v, input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
      sat = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic logic signed [31:0] mul_sh(input logic signed [31:0] a,
                                                  input logic [15:0] b,
                                                  input int sh);
      logic signed [48:0] p;
      p = a * $signed({1'b0, b});
      mul_sh = 32'(p >>> sh);
   endfunction

   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            merge[8*b +: 8] = nw[8*b +: 8];
      end
   endfunction

   function automatic logic [15:0] mag(input logic signed [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction

   // ---------------------------------------------------------------
   // Gain scheduling axis
   // ---------------------------------------------------------------
   assign mode = srg_mode_t'(st_ff.regs[SRG_R_CTRL][SRG_CTRL_MODE_LSB +: 2]);

   // Scalar mode blends from zero to fmax on the output frequency
   always_comb
   begin
      if (mode == SRG_MODE_SCALAR_ENC)
      begin
         sch_x = mag(st_ff.freq_cmd);
         sch_lo = 16'h0000;
         sch_hi = st_ff.regs[SRG_R_ILIM][31:16];
         sch_inv = st_ff.regs[SRG_R_INV][31:16];
      end
      else
      begin
         sch_x = mag(freq_ref);
         sch_lo = st_ff.regs[SRG_R_SWITCH][15:0];
         sch_hi = st_ff.regs[SRG_R_SWITCH][31:16];
         sch_inv = st_ff.regs[SRG_R_INV][15:0];
      end
   end

   assign sch_prod = 32'(sch_x - sch_lo) * 32'(sch_inv);

   always_comb
   begin
      if (sch_x <= sch_lo)
         frac = 16'h0000;
      else if (sch_x >= sch_hi)
         frac = SRG_FRAC_MAX;
      else if (sch_prod[31:16] != 16'h0000)
         frac = SRG_FRAC_MAX;
      else
         frac = sch_prod[15:0];
   end

   // Speed and observer gains: low set in SRG_R_SPD_LO/SRG_R_OBS_LO, high set in SRG_R_SPD_HI/SRG_R_OBS_HI; COMP: low in [15:0], high in [31:16]; FILT reversed
   always_comb
   begin
      blend_lo[0] = st_ff.regs[SRG_R_SPD_LO][15:0];
      blend_hi[0] = st_ff.regs[SRG_R_SPD_HI][15:0];
      blend_lo[1] = st_ff.regs[SRG_R_SPD_LO][31:16];
      blend_hi[1] = st_ff.regs[SRG_R_SPD_HI][31:16];
      blend_lo[2] = st_ff.regs[SRG_R_OBS_LO][15:0];
      blend_hi[2] = st_ff.regs[SRG_R_OBS_HI][15:0];
      blend_lo[3] = st_ff.regs[SRG_R_OBS_LO][31:16];
      blend_hi[3] = st_ff.regs[SRG_R_OBS_HI][31:16];
      blend_lo[4] = st_ff.regs[SRG_R_FILT][31:16];
      blend_hi[4] = st_ff.regs[SRG_R_FILT][15:0];
      blend_lo[5] = st_ff.regs[SRG_R_COMP][15:0];
      blend_hi[5] = st_ff.regs[SRG_R_COMP][31:16];
   end

   for (genvar g = 0; g < NBLEND; g++)
   begin : g_blend
      srg_lerp #(.W(16)) u_lerp (
         .lo_val(blend_lo[g]),
         .hi_val(blend_hi[g]),
         .frac(frac),
         .blend(blend_out[g])
      );
   end

   // ---------------------------------------------------------------
   // Bus handshakes
   // ---------------------------------------------------------------
   // Address and data are taken together; a pending response blocks both
   assign aw_go = awvalid & wvalid & ~st_ff.bvalid;
   assign awready = aw_go;
   assign wready = aw_go;
   assign arready = ~st_ff.rvalid;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin : comb
      logic signed [31:0] fb, err_o, err, p, u_pre, u, lim_p, lim_n, ilim, integ_sum, fcmd;
      logic [31:0] fmax, wval;
      logic [3:0] widx, ridx;
      logic loop_on, integ_act, tick;
      fb = 32'sh0000_0000;
      err_o = 32'sh0000_0000;
      err = 32'sh0000_0000;
      p = 32'sh0000_0000;
      u_pre = 32'sh0000_0000;
      u = 32'sh0000_0000;
      integ_sum = 32'sh0000_0000;
      fcmd = 32'sh0000_0000;
      wval = 32'h0000_0000;
      widx = awaddr[SRG_IDX_W+1:2];
      ridx = araddr[SRG_IDX_W+1:2];
      nxt_st = st_ff;
      tick = (st_ff.tick_cnt == 32'(SAMPLE_CYCLES - 1));
      fmax = {16'h0000, st_ff.regs[SRG_R_ILIM][31:16]};
      lim_p = $signed((fmax * {16'h0000, st_ff.regs[SRG_R_LIMIT][15:0]}) / SRG_PCT_DIV);
      lim_n = -$signed((fmax * {16'h0000, st_ff.regs[SRG_R_LIMIT][31:16]}) / SRG_PCT_DIV);
      ilim = $signed(((fmax * {16'h0000, st_ff.regs[SRG_R_ILIM][15:0]}) / SRG_PCT_DIV)
                     << SRG_Q_SH);
      loop_on = st_ff.regs[SRG_R_CTRL][SRG_CTRL_LOOP_EN]
                && !(mode == SRG_MODE_SCALAR_ENC && loop_off_in);
      // Ramping with select zero runs P-only and holds the integrator
      integ_act = st_ff.regs[SRG_R_CTRL][SRG_CTRL_INTEG_EN] && !integ_reset_in
                  && !(ramping && !st_ff.regs[SRG_R_CTRL][SRG_CTRL_ACCDEC]);

      // -------------------- Register writes --------------------
      if (aw_go)
      begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = SRG_RESP_OKAY;
         wval = merge(st_ff.regs[widx], wdata, wstrb);
         if (awaddr[SRG_ADDR_W-1:SRG_IDX_W+2] != '0 || widx > SRG_R_SPEED)
            nxt_st.bresp = SRG_RESP_DECERR;
         else if (widx == SRG_R_LIMIT && run)
            nxt_st.bresp = SRG_RESP_SLVERR;
         else if (widx == SRG_R_LIMIT)
            nxt_st.regs[widx] = {clamp16(wval[31:16], SRG_LIM_MIN, SRG_LIM_MAX),
                                 clamp16(wval[15:0], SRG_LIM_MIN, SRG_LIM_MAX)};
         else if (widx == SRG_R_ILIM)
            nxt_st.regs[widx] = {wval[31:16],
                                 clamp16(wval[15:0], 16'h0000, SRG_ILIM_MAX)};
         else if (widx < 4'(SRG_NUM_RW))
            nxt_st.regs[widx] = wval;
      end
      else if (st_ff.bvalid && bready)
         nxt_st.bvalid = 1'b0;

      // -------------------- Register reads ---------------------
      if (arvalid && !st_ff.rvalid)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = SRG_RESP_OKAY;
         nxt_st.rdata = 32'h0000_0000;
         if (araddr[SRG_ADDR_W-1:SRG_IDX_W+2] != '0 || ridx > SRG_R_SPEED)
            nxt_st.rresp = SRG_RESP_DECERR;
         else if (ridx == SRG_R_STATUS)
            nxt_st.rdata = {13'h0000, run, st_ff.at_lo, st_ff.at_hi, frac};
         else if (ridx == SRG_R_FREQ)
            nxt_st.rdata = {16'h0000, st_ff.freq_cmd};
         else if (ridx == SRG_R_SPEED)
            nxt_st.rdata = {16'h0000, st_ff.speed_fb};
         else
            nxt_st.rdata = st_ff.regs[ridx];
      end
      else if (st_ff.rvalid && rready)
         nxt_st.rvalid = 1'b0;

      // -------------------- Control sample ---------------------
      nxt_st.tick_cnt = tick ? 32'h0000_0000 : st_ff.tick_cnt + 32'h0000_0001;

      if (tick)
      begin
         // Estimator tracks the raw model speed with its own PI
         err_o = sat(32'(raw_speed_est) - 32'(st_ff.est), SRG_S16_MIN, SRG_S16_MAX);
         nxt_st.oint = sat(st_ff.oint + mul_sh(err_o, blend_out[3], SRG_Q_SH),
                           SRG_S16_MIN <<< SRG_Q_SH, SRG_S16_MAX <<< SRG_Q_SH);
         nxt_st.est = 16'(sat((nxt_st.oint >>> SRG_Q_SH)
                              + mul_sh(err_o, blend_out[2], SRG_GAIN_SH),
                              SRG_S16_MIN, SRG_S16_MAX));

         fb = (mode == SRG_MODE_SENSORLESS) ? 32'(st_ff.est) : 32'(encoder_speed);
         if (st_ff.regs[SRG_R_CTRL][SRG_CTRL_LPF_EN])
            nxt_st.filt = st_ff.filt
                          + mul_sh((fb <<< SRG_Q_SH) - st_ff.filt, blend_out[4], SRG_COEF_SH);
         else
            nxt_st.filt = fb <<< SRG_Q_SH;
         fb = nxt_st.filt >>> SRG_Q_SH;
         if (st_ff.regs[SRG_R_CTRL][SRG_CTRL_COMP_EN])
            fb = sat(mul_sh(fb, blend_out[5], SRG_GAIN_SH), SRG_S16_MIN, SRG_S16_MAX);
         nxt_st.speed_fb = 16'(fb);

         err = sat(32'(freq_ref) - fb, SRG_S16_MIN, SRG_S16_MAX);
         p = mul_sh(err, blend_out[0], SRG_GAIN_SH);
         u_pre = p + (integ_act ? (st_ff.integ >>> SRG_Q_SH) : 32'sh0000_0000);
         u = sat(u_pre, lim_n, lim_p);
         nxt_st.at_hi = u_pre > lim_p;
         nxt_st.at_lo = u_pre < lim_n;

         // Integration stops while the output is past a limit and the error pushes it further out
         integ_sum = sat(st_ff.integ + mul_sh(err, blend_out[1], SRG_Q_SH), -ilim, ilim);
         if (!loop_on || integ_reset_in || !st_ff.regs[SRG_R_CTRL][SRG_CTRL_INTEG_EN])
            nxt_st.integ = 32'sh0000_0000;
         else if (integ_act && !(nxt_st.at_hi && err > 0) && !(nxt_st.at_lo && err < 0))
            nxt_st.integ = integ_sum;

         if (loop_on)
            nxt_st.dfo = st_ff.dfo
                         + mul_sh((u <<< SRG_Q_SH) - st_ff.dfo,
                                  st_ff.regs[SRG_R_OUTF][15:0], SRG_COEF_SH);
         else
            nxt_st.dfo = 32'sh0000_0000;

         nxt_st.delta_f = 16'(nxt_st.dfo >>> SRG_Q_SH);
         fcmd = sat(32'(freq_ref) + 32'(nxt_st.delta_f), SRG_S16_MIN, SRG_S16_MAX);
         nxt_st.freq_cmd = 16'(fcmd);
         nxt_st.mon1 = st_ff.regs[SRG_R_CTRL][SRG_CTRL_MON1_SEL] ? 16'(fb) : 16'(fcmd);
         nxt_st.mon2 = st_ff.regs[SRG_R_CTRL][SRG_CTRL_MON2_SEL] ? 16'(fb) : 16'(fcmd);
      end

      // -------------------- Reset ------------------------------
      if (!aresetn)
      begin
         nxt_st = '0;
         for (int i = 0; i < SRG_NUM_RW; i++)
            nxt_st.regs[i] = SRG_RST_VALS[i];
      end
   end

   always_ff @(posedge aclk)
   begin
      st_ff <= nxt_st;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign rvalid = st_ff.rvalid;
   assign rresp = st_ff.rresp;
   assign rdata = st_ff.rdata;
   assign freq_cmd = st_ff.freq_cmd;
   assign delta_f = st_ff.delta_f;
   assign analog_monitor_out_1 = st_ff.mon1;
   assign analog_monitor_out_2 = st_ff.mon2;

endmodule // srg_speed_regulator
`default_nettype wire

// File: srg_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Motor with encoder: first-order lag behind the commanded frequency
// ---------------------------------------------------------------
module srg_motor_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic signed [15:0] freq_cmd,
   input wire logic signed [15:0] slip,
   output logic signed [15:0] encoder_speed,
   output logic signed [15:0] raw_speed_est
);
   logic signed [16:0] err;
   logic signed [15:0] speed_ff;
   // Slip offsets shaft speed from the command (below it for positive slip), so the loop has work whenever slip is not zero
   assign err = 17'(freq_cmd) - 17'(slip) - 17'(speed_ff);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         speed_ff <= 16'h0000;
      else
         speed_ff <= speed_ff + 16'(err >>> 3);
   end
   assign encoder_speed = speed_ff;
   assign raw_speed_est = speed_ff;
endmodule // srg_motor_model
`default_nettype wire

// File: srg_speed_regulator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module srg_speed_regulator_chk
   import srg_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SRG_SAMPLE_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SRG_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [SRG_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic run,
   input wire logic signed [15:0] freq_ref,
   input wire logic signed [15:0] freq_cmd,
   input wire logic signed [15:0] delta_f,
   input wire logic signed [15:0] analog_monitor_out_1,
   input wire logic signed [15:0] analog_monitor_out_2
);
   logic [31:0] cnt_ff;
   logic tick;
   logic wtake;
   assign tick = (cnt_ff == 32'(SAMPLE_CYCLES - 1));
   assign wtake = awvalid && wvalid && awready;
   // Mirrors the sample counter so holds can be told from updates
   always_ff @(posedge aclk)
   begin
      if (!aresetn || tick)
         cnt_ff <= 32'h0000_0000;
      else
         cnt_ff <= cnt_ff + 32'h0000_0001;
   end
   function automatic logic signed [15:0] sat16(input int v);
      if (v > SRG_S16_MAX)
         return 16'h7fff;
      if (v < SRG_S16_MIN)
         return 16'h8000;
      return 16'(v);
   endfunction
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_cmd_sum: assert property (tick |=> freq_cmd == sat16(int'($past(freq_ref)) + int'(delta_f)))
      else $error("command is not reference plus correction");
   a_hold_out: assert property (!tick |=> $stable(freq_cmd) && $stable(delta_f)
      && $stable(analog_monitor_out_1) && $stable(analog_monitor_out_2))
      else $error("outputs moved between samples");
   a_aw_pair: assert property (awready |-> wready && awvalid && wvalid && !bvalid)
      else $error("write ready without a full request");
   a_b_next: assert property (wtake |=> bvalid)
      else $error("write response late");
   a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_r_next: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped");
   a_lim_locked: assert property (wtake && run && awaddr == 8'h24 |=> bresp == SRG_RESP_SLVERR)
      else $error("limit write accepted while running");
   a_bad_addr: assert property (arvalid && arready && araddr == 8'h3c |=> rresp == SRG_RESP_DECERR && rdata == 0)
      else $error("unmapped read not refused");
endmodule // srg_speed_regulator_chk
bind srg_speed_regulator srg_speed_regulator_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (.aclk, .aresetn, .awaddr,
   .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
   .rvalid, .rready, .run, .freq_ref, .freq_cmd, .delta_f, .analog_monitor_out_1, .analog_monitor_out_2);
`default_nettype wire

// File: srg_speed_regulator_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Register and loop scenarios
// ---------------------------------------------------------------
module srg_speed_regulator_bench
   import srg_pkg::*;
;
   localparam int NS = 8;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic run, ramping, loop_off_in, integ_reset_in;
   logic signed [15:0] freq_ref, encoder_speed, raw_speed_est, freq_cmd, delta_f, slip;
   logic signed [15:0] analog_monitor_out_1, analog_monitor_out_2;
   int errors, n_compared, k;
   srg_speed_regulator #(.SAMPLE_CYCLES(NS)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .freq_ref(freq_ref),
      .encoder_speed(encoder_speed), .raw_speed_est(raw_speed_est), .run(run), .ramping(ramping),
      .loop_off_in(loop_off_in), .integ_reset_in(integ_reset_in), .freq_cmd(freq_cmd), .delta_f(delta_f),
      .analog_monitor_out_1(analog_monitor_out_1), .analog_monitor_out_2(analog_monitor_out_2));
   srg_motor_model motor_u (.aclk(aclk), .aresetn(aresetn), .freq_cmd(freq_cmd), .slip(slip),
      .encoder_speed(encoder_speed), .raw_speed_est(raw_speed_est));
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic give_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic c, input string m);
      n_compared++;
      if (c !== 1'b1)
      begin
         errors++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task automatic step(inout int i, input string m);
      @(posedge aclk);
      i++;
      if (i > 100)
      begin
         cmp(1'b0, m);
         give_verdict();
      end
   endtask
   // Each transfer starts one edge late so no signal is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      i = 0;
      do step(i, "write not taken"); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do step(i, "no write response"); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      i = 0;
      do step(i, "read not taken"); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do step(i, "no read data"); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      wr(a, d, r);
      cmp(r === er, "write response");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      cmp(d === ed && r === er, "read value");
   endtask
   task automatic ticks(input int n);
      repeat (n * NS) @(posedge aclk);
   endtask
   initial
   begin
      repeat (90000) @(posedge aclk);
      cmp(1'b0, "run timeout");
      give_verdict();
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, run, ramping, loop_off_in, integ_reset_in} = '0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hf;
      freq_ref = 16'h0000;
      slip = 16'h0000;
      errors = 0;
      n_compared = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < SRG_NUM_RW; k++)
         rchk(8'(4 * k), SRG_RST_VALS[k], SRG_RESP_OKAY);
      $display("test reset values done");
      wchk(8'h24, 32'h0000_0200, SRG_RESP_OKAY);
      rchk(8'h24, 32'h0001_0064, SRG_RESP_OKAY);
      wchk(8'h28, 32'h0258_ffff, SRG_RESP_OKAY);
      rchk(8'h28, 32'h0258_0bb8, SRG_RESP_OKAY);
      run <= 1'b1;
      wchk(8'h24, 32'h0032_0032, SRG_RESP_SLVERR);
      rchk(8'h24, 32'h0001_0064, SRG_RESP_OKAY);
      run <= 1'b0;
      wchk(8'h24, 32'h0032_0032, SRG_RESP_OKAY);
      wchk(8'h28, 32'h0258_03e8, SRG_RESP_OKAY);
      wchk(8'h3c, 32'h0000_0000, SRG_RESP_DECERR);
      rchk(8'h3c, 32'h0000_0000, SRG_RESP_DECERR);
      wchk(8'h30, 32'hffff_ffff, SRG_RESP_OKAY);
      $display("test register access done");
      // Monitor 1 on frequency command, loop on, filter and compensation off
      wchk(8'h00, 32'h0000_0118, SRG_RESP_OKAY);
      run <= 1'b1;
      freq_ref <= 16'h012c;
      slip <= 16'h000a;
      ticks(100);
      cmp(delta_f > 0 && delta_f <= 30 && freq_cmd === freq_ref + delta_f, "small correction");
      cmp(analog_monitor_out_1 === freq_cmd, "monitor not frequency");
      // Limit is 5 percent of 60 Hz, so 30 counts either way
      slip <= 16'h0190;
      ticks(40);
      cmp(delta_f >= 25 && delta_f <= 30, "positive limit");
      slip <= 16'hfe70;
      ticks(40);
      cmp(delta_f <= -25 && delta_f >= -30, "negative limit");
      loop_off_in <= 1'b1;
      ticks(20);
      cmp(delta_f >= -1 && delta_f <= 1, "loop not disabled");
      // Loop open: shaft settles just under reference plus 40 Hz of negative slip
      cmp(analog_monitor_out_2 >= 690 && analog_monitor_out_2 <= 700, "monitor not speed");
      $display("test scalar loop done");
      slip <= 16'h0190;
      ramping <= 1'b1;
      integ_reset_in <= 1'b1;
      for (k = 1; k < 4; k++)
      begin
         wchk(8'h00, 32'h0000_0118 | 32'(k), SRG_RESP_OKAY);
         ticks(40);
         cmp(delta_f >= 25 && delta_f <= 30, "mode loop inactive");
      end
      $display("test vector modes done");
      give_verdict();
   end
endmodule // srg_speed_regulator_bench
`default_nettype wire
